/* core/i2c_port_defs.svh */
// Timing counts, addresses and sizes for the two-wire port block
`ifndef I2C_PORT_DEFS_SVH
`define I2C_PORT_DEFS_SVH
`define SYS_CLK_PERIOD_NS 25
`define NS_TO_CYC(ns) (((ns) + `SYS_CLK_PERIOD_NS - 1) / `SYS_CLK_PERIOD_NS)
`define DEGLITCH_NS 50
`define DEGLITCH_CYC `NS_TO_CYC(`DEGLITCH_NS)
`define STD_LOW_NS 4700
`define STD_HIGH_NS 4000
`define FAST_LOW_NS 1300
`define FAST_HIGH_NS 600
`define STD_LOW_CYC `NS_TO_CYC(`STD_LOW_NS)
`define STD_HIGH_CYC `NS_TO_CYC(`STD_HIGH_NS)
`define FAST_LOW_CYC `NS_TO_CYC(`FAST_LOW_NS)
`define FAST_HIGH_CYC `NS_TO_CYC(`FAST_HIGH_NS)
`define BOOT_CYC 3
`define DUAL_ADDR_UPPER 4'h2
`define TARGET_ONLY_ADDR 7'h38
`define BYTE_BITS 8
`define FIFO_DEPTH 4
`define PEND_ADDRESSED 0
`define PEND_STOP 1
`endif

/* core/i2c_port_pkg.sv */
// Types shared by the two-wire port block
package i2c_port_pkg;
  typedef enum logic [2:0] {
    T_IDLE = 3'h0,
    T_ADDR = 3'h1,
    T_ADDR_ACK = 3'h3,
    T_RX = 3'h2,
    T_RX_ACK = 3'h6,
    T_TX = 3'h7,
    T_TX_ACK = 3'h5,
    T_SKIP = 3'h4
  } tgt_state_t;
  typedef enum logic [2:0] {
    C_IDLE = 3'h0,
    C_START = 3'h1,
    C_LOW = 3'h3,
    C_HIGH = 3'h2,
    C_STOP = 3'h6
  } ctl_state_t;
  typedef enum logic [1:0] {
    CMD_START = 2'h0,
    CMD_WRITE = 2'h1,
    CMD_READ = 2'h2,
    CMD_STOP = 2'h3
  } ctl_cmd_t;
endpackage

/* core/byte_fifo.sv */
// Small first-in first-out buffer with valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none
module byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic wr_valid,
  output logic wr_ready,
  input wire logic [WIDTH-1:0] wr_data,
  output logic rd_valid,
  input wire logic rd_ready,
  output logic [WIDTH-1:0] rd_data
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] count;
  } fifo_state_t;
  fifo_state_t q;
  fifo_state_t n;
  logic do_wr;
  logic do_rd;

  assign wr_ready = q.count != (AW+1)'(DEPTH);
  assign rd_valid = q.count != '0;
  assign rd_data = q.mem[q.rp];

  always_comb begin
    do_wr = wr_valid && wr_ready;
    do_rd = rd_valid && rd_ready;
    n = q;
    if (do_wr) begin
      n.mem[q.wp] = wr_data;
      n.wp = q.wp + 1'b1;
    end
    if (do_rd) begin
      n.rp = q.rp + 1'b1;
    end
    n.count = q.count + (AW+1)'(do_wr) - (AW+1)'(do_rd);
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end
endmodule
`default_nettype wire

/* core/i2c_host_port_interface.sv */
// Three two-wire serial ports: dual-role, target-only and controller-only
`include "i2c_port_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module i2c_host_port_interface
  import i2c_port_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic dual_role_port_scl_in,
  output logic dual_role_port_scl_out,
  output logic dual_role_port_scl_oe,
  input wire logic dual_role_port_sda_in,
  output logic dual_role_port_sda_out,
  output logic dual_role_port_sda_oe,
  input wire logic target_only_port_scl_in,
  output logic target_only_port_scl_out,
  output logic target_only_port_scl_oe,
  input wire logic target_only_port_sda_in,
  output logic target_only_port_sda_out,
  output logic target_only_port_sda_oe,
  input wire logic controller_only_port_scl_in,
  output logic controller_only_port_scl_out,
  output logic controller_only_port_scl_oe,
  input wire logic controller_only_port_sda_in,
  output logic controller_only_port_sda_out,
  output logic controller_only_port_sda_oe,
  input wire logic [2:0] address_strap_pin,
  input wire logic dual_role_ctrl_mode,
  input wire logic [1:0][6:0] tgt_addr_mask,
  input wire logic [1:0][6:0] tgt_addr_override,
  output logic [1:0][7:0] tgt_rx_data,
  output logic [1:0] tgt_rx_valid,
  input wire logic [1:0] tgt_rx_ready,
  input wire logic [1:0][7:0] tgt_tx_data,
  input wire logic [1:0] tgt_tx_valid,
  output logic [1:0] tgt_tx_ready,
  input wire logic [7:0] core_event,
  input wire logic [1:0][7:0] tgt_irq_mask,
  input wire logic [1:0][7:0] tgt_irq_clear,
  output logic dual_role_port_irq,
  output logic target_only_port_irq,
  input wire logic fast_mode,
  input wire logic [1:0][1:0] ctl_cmd,
  input wire logic [1:0] ctl_cmd_valid,
  output logic [1:0] ctl_cmd_ready,
  input wire logic [1:0][7:0] ctl_wdata,
  input wire logic [1:0] ctl_rd_nack,
  output logic [1:0][7:0] ctl_rdata,
  output logic [1:0] ctl_done,
  output logic [1:0] ctl_nack,
  output logic controller_port_irq,
  input wire logic controller_port_irq_clear
);
  typedef struct packed {
    logic [5:0] s1;
    logic [5:0] s2;
    logic [5:0] line;
    logic [5:0] line_d;
    logic [5:0][1:0] dg;
    logic [2:0] strap_s1;
    logic [2:0] strap_s2;
    logic [2:0] strap;
    logic [1:0] boot_cnt;
    logic booted;
    tgt_state_t [1:0] ts;
    logic [1:0][7:0] tsh;
    logic [1:0][3:0] tcnt;
    logic [1:0] trw;
    logic [1:0] tsda_oe;
    logic [1:0] tscl_oe;
    logic [1:0][7:0] pend;
    ctl_state_t [1:0] cs;
    logic [1:0][8:0] csh;
    logic [1:0][3:0] ccnt;
    logic [1:0][7:0] ctim;
    logic [1:0] csda_oe;
    logic [1:0] cscl_oe;
    logic [1:0] held;
    logic [1:0] busy;
    logic [1:0] cdone;
    logic [1:0] cnack;
    logic [1:0][7:0] crx;
    logic cirq;
  } core_state_t;

  core_state_t q;
  core_state_t n;
  logic [1:0] push;
  logic [1:0] push_ready;
  logic [5:0] pin_in;

  function automatic logic [6:0] addr_of(input logic [6:0] dflt, input logic [6:0] mask,
                                         input logic [6:0] ovr);
    addr_of = (dflt & ~mask) | (ovr & mask);
  endfunction

  // Index 0/1 dual-role, 2/3 target-only, 4/5 controller-only (clock, data)
  assign pin_in = {controller_only_port_sda_in, controller_only_port_scl_in,
                   target_only_port_sda_in, target_only_port_scl_in,
                   dual_role_port_sda_in, dual_role_port_scl_in};

  // --------------------------------------------------------------------
  // Next state
  // --------------------------------------------------------------------
  always_comb begin
    logic sclh, sdah, rise, fall, start, stop, en, tim_done;
    logic [6:0] dflt, addr;
    logic [7:0] lo_cyc, hi_cyc;
    int k;
    sclh = 1'b0;
    sdah = 1'b0;
    rise = 1'b0;
    fall = 1'b0;
    start = 1'b0;
    stop = 1'b0;
    en = 1'b0;
    tim_done = 1'b0;
    dflt = '0;
    addr = '0;
    k = 0;
    lo_cyc = fast_mode ? 8'(`FAST_LOW_CYC) : 8'(`STD_LOW_CYC);
    hi_cyc = fast_mode ? 8'(`FAST_HIGH_CYC) : 8'(`STD_HIGH_CYC);
    n = q;
    push = '0;
    tgt_tx_ready = '0;
    ctl_cmd_ready = '0;
    n.s1 = pin_in;
    n.s2 = q.s1;
    n.line_d = q.line;
    for (int i = 0; i < 6; i++) begin
      if (q.s2[i] == q.line[i]) begin
        n.dg[i] = 2'h0;
      end else if (q.dg[i] == 2'(`DEGLITCH_CYC - 1)) begin
        n.line[i] = q.s2[i];
        n.dg[i] = 2'h0;
      end else begin
        n.dg[i] = q.dg[i] + 2'h1;
      end
    end
    // Strap code is caught once, a few cycles after reset release
    n.strap_s1 = address_strap_pin;
    n.strap_s2 = q.strap_s1;
    if (!q.booted) begin
      n.boot_cnt = q.boot_cnt + 2'h1;
      if (q.boot_cnt == 2'(`BOOT_CYC)) begin
        n.strap = q.strap_s2;
        n.booted = 1'b1;
      end
    end

    // ------------------------------------------------------------------
    // Target engines: 0 dual-role, 1 target-only
    // ------------------------------------------------------------------
    for (int p = 0; p < 2; p++) begin
      k = 2 * p;
      sclh = q.line[k];
      sdah = q.line[k+1];
      rise = q.line[k] & ~q.line_d[k];
      fall = ~q.line[k] & q.line_d[k];
      start = q.line_d[k] & sclh & q.line_d[k+1] & ~sdah;
      stop = q.line_d[k] & sclh & ~q.line_d[k+1] & sdah;
      en = (p == 1) || (!dual_role_ctrl_mode && q.booted);
      dflt = (p == 0) ? {`DUAL_ADDR_UPPER, q.strap} : `TARGET_ONLY_ADDR;
      addr = addr_of(dflt, tgt_addr_mask[p], tgt_addr_override[p]);
      n.pend[p] = (q.pend[p] & ~tgt_irq_clear[p]) | core_event;
      if (!en) begin
        n.ts[p] = T_IDLE;
        n.tsda_oe[p] = 1'b0;
        n.tscl_oe[p] = 1'b0;
      end else if (start) begin
        n.ts[p] = T_ADDR;
        n.tcnt[p] = 4'h0;
        n.tsda_oe[p] = 1'b0;
        n.tscl_oe[p] = 1'b0;
      end else if (stop) begin
        if (q.ts[p] != T_IDLE && q.ts[p] != T_SKIP) begin
          n.pend[p][`PEND_STOP] = 1'b1;
        end
        n.ts[p] = T_IDLE;
        n.tsda_oe[p] = 1'b0;
        n.tscl_oe[p] = 1'b0;
      end else begin
        unique case (q.ts[p])
          T_IDLE, T_SKIP: begin
            n.tsda_oe[p] = 1'b0;
          end
          T_ADDR, T_RX: begin
            if (rise && q.tcnt[p] != 4'(`BYTE_BITS)) begin
              n.tsh[p] = {q.tsh[p][6:0], sdah};
              n.tcnt[p] = q.tcnt[p] + 4'h1;
            end else if (q.tcnt[p] == 4'(`BYTE_BITS) && !sclh) begin
              if (q.ts[p] == T_RX) begin
                if (push_ready[p]) begin
                  push[p] = 1'b1;
                  n.ts[p] = T_RX_ACK;
                  n.tsda_oe[p] = 1'b1;
                  n.tscl_oe[p] = 1'b0;
                end else begin
                  n.tscl_oe[p] = 1'b1;
                end
              end else if (q.tsh[p][7:1] == addr) begin
                n.ts[p] = T_ADDR_ACK;
                n.tsda_oe[p] = 1'b1;
                n.trw[p] = q.tsh[p][0];
                n.pend[p][`PEND_ADDRESSED] = 1'b1;
              end else begin
                n.ts[p] = T_SKIP;
              end
            end
          end
          T_ADDR_ACK, T_RX_ACK: begin
            if (fall) begin
              n.tsda_oe[p] = 1'b0;
              n.tcnt[p] = 4'h0;
              n.ts[p] = q.trw[p] ? T_TX : T_RX;
            end
          end
          T_TX: begin
            if (q.tcnt[p] == 4'h0) begin
              if (!sclh) begin
                tgt_tx_ready[p] = 1'b1;
                if (tgt_tx_valid[p]) begin
                  n.tsh[p] = tgt_tx_data[p];
                  n.tsda_oe[p] = ~tgt_tx_data[p][7];
                  n.tcnt[p] = 4'h1;
                  n.tscl_oe[p] = 1'b0;
                end else begin
                  n.tscl_oe[p] = 1'b1;
                end
              end
            end else if (fall) begin
              if (q.tcnt[p] == 4'(`BYTE_BITS)) begin
                n.tsda_oe[p] = 1'b0;
                n.ts[p] = T_TX_ACK;
              end else begin
                n.tsh[p] = {q.tsh[p][6:0], 1'b0};
                n.tsda_oe[p] = ~q.tsh[p][6];
                n.tcnt[p] = q.tcnt[p] + 4'h1;
              end
            end
          end
          T_TX_ACK: begin
            if (rise && sdah) begin
              n.ts[p] = T_SKIP;
            end else if (fall) begin
              n.ts[p] = T_TX;
              n.tcnt[p] = 4'h0;
            end
          end
        endcase
      end
    end

    // ------------------------------------------------------------------
    // Controller engines: 0 dual-role, 1 controller-only
    // ------------------------------------------------------------------
    for (int c = 0; c < 2; c++) begin
      k = (c == 0) ? 0 : 4;
      sclh = q.line[k];
      sdah = q.line[k+1];
      start = q.line_d[k] & sclh & q.line_d[k+1] & ~sdah;
      stop = q.line_d[k] & sclh & ~q.line_d[k+1] & sdah;
      en = (c == 1) || dual_role_ctrl_mode;
      tim_done = q.ctim[c] == 8'h0;
      n.cdone[c] = 1'b0;
      if (start) begin
        n.busy[c] = 1'b1;
      end else if (stop) begin
        n.busy[c] = 1'b0;
      end
      if (!tim_done) begin
        n.ctim[c] = q.ctim[c] - 8'h1;
      end
      if (!en) begin
        n.cs[c] = C_IDLE;
        n.csda_oe[c] = 1'b0;
        n.cscl_oe[c] = 1'b0;
        n.held[c] = 1'b0;
      end else begin
        unique case (q.cs[c])
          C_IDLE: begin
            if (ctl_cmd[c] == CMD_START) begin
              ctl_cmd_ready[c] = !q.busy[c] || q.held[c];
            end else begin
              ctl_cmd_ready[c] = q.held[c];
            end
            if (ctl_cmd_valid[c] && ctl_cmd_ready[c]) begin
              n.ccnt[c] = 4'h0;
              n.ctim[c] = lo_cyc;
              unique case (ctl_cmd_t'(ctl_cmd[c]))
                CMD_START: begin
                  n.cs[c] = C_START;
                  n.csda_oe[c] = 1'b0;
                end
                CMD_WRITE: begin
                  n.cs[c] = C_LOW;
                  n.csh[c] = {ctl_wdata[c], 1'b1};
                end
                CMD_READ: begin
                  n.cs[c] = C_LOW;
                  n.csh[c] = {8'hff, ctl_rd_nack[c]};
                end
                CMD_STOP: begin
                  n.cs[c] = C_STOP;
                  n.csda_oe[c] = 1'b1;
                end
              endcase
            end
          end
          C_START: begin
            if (q.ccnt[c] == 4'h0) begin
              if (tim_done) begin
                n.cscl_oe[c] = 1'b0;
                n.ccnt[c] = 4'h1;
                n.ctim[c] = hi_cyc;
              end
            end else if (q.ccnt[c] == 4'h1) begin
              if (!sclh) begin
                n.ctim[c] = hi_cyc;
              end else if (tim_done) begin
                n.csda_oe[c] = 1'b1;
                n.ccnt[c] = 4'h2;
                n.ctim[c] = hi_cyc;
              end
            end else if (tim_done) begin
              n.cscl_oe[c] = 1'b1;
              n.held[c] = 1'b1;
              n.cdone[c] = 1'b1;
              n.cs[c] = C_IDLE;
            end
          end
          C_LOW: begin
            n.cscl_oe[c] = 1'b1;
            n.csda_oe[c] = ~q.csh[c][8];
            if (tim_done) begin
              n.cscl_oe[c] = 1'b0;
              n.ctim[c] = hi_cyc;
              n.cs[c] = C_HIGH;
            end
          end
          C_HIGH: begin
            if (!sclh) begin
              n.ctim[c] = hi_cyc;
            end else if (tim_done) begin
              n.csh[c] = {q.csh[c][7:0], sdah};
              n.cscl_oe[c] = 1'b1;
              if (q.ccnt[c] == 4'(`BYTE_BITS)) begin
                n.crx[c] = q.csh[c][7:0];
                n.cnack[c] = sdah;
                n.cdone[c] = 1'b1;
                n.cs[c] = C_IDLE;
              end else begin
                n.ccnt[c] = q.ccnt[c] + 4'h1;
                n.ctim[c] = lo_cyc;
                n.cs[c] = C_LOW;
              end
            end
          end
          C_STOP: begin
            if (q.ccnt[c] == 4'h0) begin
              if (tim_done) begin
                n.cscl_oe[c] = 1'b0;
                n.ccnt[c] = 4'h1;
                n.ctim[c] = hi_cyc;
              end
            end else if (!sclh) begin
              n.ctim[c] = hi_cyc;
            end else if (tim_done) begin
              n.csda_oe[c] = 1'b0;
              n.held[c] = 1'b0;
              n.cdone[c] = 1'b1;
              n.cs[c] = C_IDLE;
            end
          end
          default: begin
            n.cs[c] = C_IDLE;
          end
        endcase
      end
    end
    // Set wins over clear
    n.cirq = (q.cirq & ~controller_port_irq_clear) | (q.cdone[1] & q.cnack[1]);
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  // --------------------------------------------------------------------
  // Receive buffers toward the core
  // --------------------------------------------------------------------
  for (genvar p = 0; p < 2; p++) begin : g_rx_fifo
    byte_fifo #(.WIDTH(8), .DEPTH(`FIFO_DEPTH)) u_fifo (
      .sys_clk(sys_clk),
      .rstn(rstn),
      .wr_valid(push[p]),
      .wr_ready(push_ready[p]),
      .wr_data(q.tsh[p]),
      .rd_valid(tgt_rx_valid[p]),
      .rd_ready(tgt_rx_ready[p]),
      .rd_data(tgt_rx_data[p])
    );
  end

  // --------------------------------------------------------------------
  // Pads and outputs (open drain: output level is always low)
  // --------------------------------------------------------------------
  assign dual_role_port_scl_out = 1'b0;
  assign dual_role_port_sda_out = 1'b0;
  assign target_only_port_scl_out = 1'b0;
  assign target_only_port_sda_out = 1'b0;
  assign controller_only_port_scl_out = 1'b0;
  assign controller_only_port_sda_out = 1'b0;
  assign dual_role_port_scl_oe = q.tscl_oe[0] | q.cscl_oe[0];
  assign dual_role_port_sda_oe = q.tsda_oe[0] | q.csda_oe[0];
  assign target_only_port_scl_oe = q.tscl_oe[1];
  assign target_only_port_sda_oe = q.tsda_oe[1];
  assign controller_only_port_scl_oe = q.cscl_oe[1];
  assign controller_only_port_sda_oe = q.csda_oe[1];
  assign dual_role_port_irq = |(q.pend[0] & tgt_irq_mask[0]);
  assign target_only_port_irq = |(q.pend[1] & tgt_irq_mask[1]);
  assign ctl_rdata = q.crx;
  assign ctl_done = q.cdone;
  assign ctl_nack = q.cnack;
  assign controller_port_irq = q.cirq;

  // --------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------
  logic t1_rise;
  logic t1_start;
  logic t1_stop;
  logic t1_byte_end;
  logic [6:0] t1_addr;
  assign t1_rise = q.line[2] & ~q.line_d[2];
  assign t1_start = q.line_d[2] & q.line[2] & q.line_d[3] & ~q.line[3];
  assign t1_stop = q.line_d[2] & q.line[2] & ~q.line_d[3] & q.line[3];
  assign t1_byte_end = q.tcnt[1] == 4'(`BYTE_BITS) && !q.line[2] && !t1_start && !t1_stop;
  assign t1_addr = addr_of(`TARGET_ONLY_ADDR, tgt_addr_mask[1], tgt_addr_override[1]);

  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  sequence s_addr_match;
    q.ts[1] == T_ADDR && t1_byte_end && q.tsh[1][7:1] == t1_addr;
  endsequence
  sequence s_addr_miss;
    q.ts[1] == T_ADDR && t1_byte_end && q.tsh[1][7:1] != t1_addr;
  endsequence

  a_start_opens_addr: assert property (t1_start |=> q.ts[1] == T_ADDR)
    else $error("start did not open address phase");
  a_stop_ends_frame: assert property (t1_stop |=> q.ts[1] == T_IDLE)
    else $error("stop did not end frame");
  a_addr_acked: assert property (s_addr_match |=> target_only_port_sda_oe [*2])
    else $error("matching address not acknowledged");
  a_addr_miss_ignored: assert property (s_addr_miss |=> q.ts[1] == T_SKIP && !target_only_port_sda_oe)
    else $error("foreign address not ignored");
  a_rx_byte_acked: assert property (push[1] |=> q.ts[1] == T_RX_ACK && target_only_port_sda_oe)
    else $error("received byte not acknowledged");
  a_full_stretches: assert property (q.ts[1] == T_RX && t1_byte_end && !push_ready[1]
    |=> target_only_port_scl_oe)
    else $error("full buffer did not stretch clock");
  a_nack_releases: assert property (q.ts[1] == T_TX_ACK && t1_rise && q.line[3] && !t1_stop
    |=> !target_only_port_sda_oe [*3])
    else $error("data not released after not-acknowledge");
  a_irq_masked: assert property (tgt_irq_mask[1] == 8'h00 |-> !target_only_port_irq)
    else $error("interrupt raised for masked event");
  a_dual_target_default: assert property (!dual_role_ctrl_mode && !$past(dual_role_ctrl_mode)
    |-> q.cs[0] == C_IDLE && !q.cscl_oe[0] && !q.csda_oe[0])
    else $error("dual-role port acting as controller in target mode");
  a_start_on_idle: assert property (ctl_cmd_valid[1] && ctl_cmd_ready[1] && ctl_cmd[1] == CMD_START
    |-> !q.busy[1] || q.held[1])
    else $error("controller started on a busy bus");
  a_target_no_drive_clk: assert property (target_only_port_scl_oe
    |-> q.ts[1] == T_RX || q.ts[1] == T_TX)
    else $error("target-only port drove clock outside a stretch");
endmodule
`default_nettype wire

/* dv/bus_host_model.sv */
// Two-wire bus controller model that drives one target port
`timescale 1ns/1ps
`default_nettype none
module bus_host_model (
  input wire logic scl,
  input wire logic sda,
  output logic scl_low,
  output logic sda_low
);
  initial begin
    scl_low = 1'b0;
    sda_low = 1'b0;
  end
  // Low and high phases leave room for the port's input filter delay
  task automatic pulse(output logic s);
    #150;
    scl_low = 1'b0;
    wait (scl === 1'b1);
    #200;
    s = sda;
    scl_low = 1'b1;
    #150;
  endtask
  task automatic start_cond();
    wait (scl === 1'b1 && sda === 1'b1);
    sda_low = 1'b1;
    #100;
    scl_low = 1'b1;
    #50;
  endtask
  task automatic stop_cond();
    sda_low = 1'b1;
    #150;
    scl_low = 1'b0;
    wait (scl === 1'b1);
    #200;
    sda_low = 1'b0;
    #400;
  endtask
  task automatic send(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      sda_low = ~b[i];
      pulse(s);
    end
    sda_low = 1'b0;
    pulse(s);
    ack = ~s;
  endtask
  task automatic recv(input logic nack, output logic [7:0] b);
    logic s;
    sda_low = 1'b0;
    for (int i = 7; i >= 0; i--) begin
      pulse(s);
      b[i] = s;
    end
    sda_low = ~nack;
    pulse(s);
    sda_low = 1'b0;
  endtask
endmodule
`default_nettype wire

/* dv/tb_i2c_host_port_interface.sv */
// Self-checking bench for the two-wire port block
`timescale 1ns/1ps
`default_nettype none
module tb_i2c_host_port_interface
  import i2c_port_pkg::*;
;
  logic sys_clk, rstn, dual_role_ctrl_mode, fast_mode, controller_port_irq_clear, ack;
  logic dual_role_port_scl_in, dual_role_port_scl_out, dual_role_port_scl_oe;
  logic dual_role_port_sda_in, dual_role_port_sda_out, dual_role_port_sda_oe;
  logic target_only_port_scl_in, target_only_port_scl_out, target_only_port_scl_oe;
  logic target_only_port_sda_in, target_only_port_sda_out, target_only_port_sda_oe;
  logic controller_only_port_scl_in, controller_only_port_scl_out, controller_only_port_scl_oe;
  logic controller_only_port_sda_in, controller_only_port_sda_out, controller_only_port_sda_oe;
  logic [2:0] address_strap_pin;
  logic [1:0][6:0] tgt_addr_mask, tgt_addr_override;
  logic [1:0][7:0] tgt_rx_data, tgt_tx_data, tgt_irq_mask, tgt_irq_clear, ctl_rdata, ctl_wdata;
  logic [1:0][1:0] ctl_cmd;
  logic [1:0] tgt_rx_valid, tgt_rx_ready, tgt_tx_valid, tgt_tx_ready, ctl_cmd_valid;
  logic [1:0] ctl_cmd_ready, ctl_rd_nack, ctl_done, ctl_nack;
  logic [7:0] core_event, rb;
  logic dual_role_port_irq, target_only_port_irq, controller_port_irq, h0s, h0d, h1s, h1d;
  int err_total = 0;
  int samples_checked = 0;
  int cyc = 0;
  // Open-drain lines with pull-ups
  assign dual_role_port_scl_in = ~(h0s | dual_role_port_scl_oe);
  assign dual_role_port_sda_in = ~(h0d | dual_role_port_sda_oe);
  assign target_only_port_scl_in = ~(h1s | target_only_port_scl_oe);
  assign target_only_port_sda_in = ~(h1d | target_only_port_sda_oe);
  assign controller_only_port_scl_in = ~controller_only_port_scl_oe;
  assign controller_only_port_sda_in = ~controller_only_port_sda_oe;
  i2c_host_port_interface dut (.*);
  bus_host_model h0 (.scl(dual_role_port_scl_in), .sda(dual_role_port_sda_in),
    .scl_low(h0s), .sda_low(h0d));
  bus_host_model h1 (.scl(target_only_port_scl_in), .sda(target_only_port_sda_in),
    .scl_low(h1s), .sda_low(h1d));
  always #12.5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      tally_and_finish();
    end
  end
  task automatic tick();
    @(posedge sys_clk);
    #2;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic t_write();
    h1.start_cond();
    h1.send({7'h38, 1'b0}, ack);
    chk(ack, 1);
    h1.send(8'ha5, ack);
    chk(ack, 1);
    h1.stop_cond();
    for (int k = 0; k < 50 && tgt_rx_valid[1] !== 1'b1; k++) tick();
    chk(tgt_rx_data[1], 8'ha5);
    chk(target_only_port_irq, 1);
    chk(dual_role_port_irq, 0);
    tgt_rx_ready[1] = 1'b1;
    tgt_irq_clear[1] = 8'hff;
    tick();
    tgt_rx_ready[1] = 1'b0;
    tgt_irq_clear[1] = 8'h00;
    tick();
    chk(target_only_port_irq, 0);
    $display("write test done");
  endtask
  task automatic t_foreign();
    h1.start_cond();
    h1.send({7'h11, 1'b0}, ack);
    chk(ack, 0);
    h1.stop_cond();
    tick();
    chk(target_only_port_irq, 0);
    $display("foreign test done");
  endtask
  task automatic t_dual();
    h0.start_cond();
    h0.send({4'h2, 3'h5, 1'b0}, ack);
    chk(ack, 1);
    h0.stop_cond();
    $display("dual test done");
  endtask
  task automatic t_read();
    tgt_tx_data[1] = 8'h3c;
    tgt_tx_valid[1] = 1'b1;
    h1.start_cond();
    h1.send({7'h38, 1'b1}, ack);
    chk(ack, 1);
    h1.recv(1'b1, rb);
    chk(rb, 8'h3c);
    chk(target_only_port_sda_oe, 0);
    h1.stop_cond();
    tgt_tx_valid[1] = 1'b0;
    $display("read test done");
  endtask
  task automatic ctl_op(input logic [1:0] c, input logic [7:0] d);
    ctl_cmd[1] = c;
    ctl_wdata[1] = d;
    ctl_cmd_valid[1] = 1'b1;
    while (ctl_cmd_ready[1] !== 1'b1) tick();
    tick();
    ctl_cmd_valid[1] = 1'b0;
    while (ctl_done[1] !== 1'b1) tick();
  endtask
  task automatic t_ctl();
    fast_mode = 1'b1;
    ctl_op(CMD_START, 8'h00);
    chk(controller_only_port_scl_oe, 1);
    ctl_op(CMD_WRITE, 8'h5a);
    chk(ctl_rdata[1], 8'h5a);
    chk(ctl_nack[1], 1);
    tick();
    chk(controller_port_irq, 1);
    controller_port_irq_clear = 1'b1;
    tick();
    controller_port_irq_clear = 1'b0;
    chk(controller_port_irq, 0);
    ctl_op(CMD_STOP, 8'h00);
    chk(controller_only_port_sda_oe, 0);
    fast_mode = 1'b0;
    $display("controller test done");
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  initial begin
    sys_clk = 1'b0;
    rstn = 1'b0;
    address_strap_pin = 3'h5;
    {dual_role_ctrl_mode, fast_mode, controller_port_irq_clear, core_event} = '0;
    {tgt_addr_mask, tgt_addr_override, tgt_rx_ready, tgt_tx_data, tgt_tx_valid} = '0;
    {tgt_irq_clear, ctl_cmd, ctl_cmd_valid, ctl_wdata, ctl_rd_nack} = '0;
    tgt_irq_mask = {8'h01, 8'h00};
    repeat (10) tick();
    rstn = 1'b1;
    repeat (20) tick();
    t_write();
    t_foreign();
    t_dual();
    t_read();
    t_ctl();
    tally_and_finish();
  end
endmodule
`default_nettype wire
